// >>> logic/can_control_consts.svh
// Bit positions, reset values and timing counts of the CAN control register
`ifndef CAN_CONTROL_CONSTS_SVH
`define CAN_CONTROL_CONSTS_SVH
`define CC_GAP_MSB        31
`define CC_GAP_LSB        28
`define CC_ABORT_BIT      27
`define CC_REQ_MSB        26
`define CC_REQ_LSB        24
`define CC_STAT_MSB       23
`define CC_STAT_LSB       21
`define CC_TXQ_BIT        20
`define CC_STORE_BIT      19
`define CC_SERR_BIT       18
`define CC_ESI_BIT        17
`define CC_RTX_BIT        16
`define CC_BRS_BIT        12
`define CC_BUSY_BIT       11
`define CC_WFT_MSB        10
`define CC_WFT_LSB        9
`define CC_WAKE_BIT       8
`define CC_PXE_BIT        6
`define CC_CRC_BIT        5
`define CC_DN_MSB         4
`define CC_DN_LSB         0
`define CC_RESET_VALUE    32'h0498_0760
`define CC_DN_MAX         5'h12
`define CC_GAP_SAT        4'hc
`define CC_MODE_SETTLE    4'h4
`endif

// >>> logic/can_control_pkg.sv
// Types shared by the CAN control register
package can_control_pkg;
   typedef enum logic [2:0] {
      MODE_NORMAL_FD  = 3'b000,
      MODE_SLEEP      = 3'b001,
      MODE_INT_LOOP   = 3'b010,
      MODE_LISTEN     = 3'b011,
      MODE_CONFIG     = 3'b100,
      MODE_EXT_LOOP   = 3'b101,
      MODE_CLASSIC    = 3'b110,
      MODE_RESTRICTED = 3'b111
   } mode_t;

   typedef struct packed {
      logic       transmitQueueEnable;
      logic       eventStoreEnable;
      logic       systemErrorModeSelect;
      logic       gatewayEsiMode;
      logic       retransmitRestrict;
      logic       rateSwitchDisable;
      logic       protocolExceptionDisable;
      logic       standardCrcEnable;
      logic       fdAllowed;
      logic [4:0] dataByteFilterCount;
   } ctrl_t;

   typedef struct packed {
      logic        write;
      logic        read;
      logic [31:0] wdata;
      logic [3:0]  byteEn;
   } reg_req_t;
endpackage : can_control_pkg

// >>> logic/can_control.sv
// CAN FD control and mode register with mode sequencing, abort and transmit gap
//
// How it works
// - Gap code doubles from two, saturates 4096
// - Abort bit held until all FIFOs aborted
// - Mode request field selects eight modes
// - Mode status mirrors active mode, config reset
// - Classic-only mode disallows FD frames
// - Queue enable reserves memory for queue
// - Event store bit enables transmit event recording
// - System error goes listen-only or restricted
// - Gateway ESI recessive on message or passive
// - Restrict bit enables per-FIFO attempt limit
// - Disable bit forbids any bit-rate switch
// - Config-only fields written only in config
// - Unimplemented bits read as zero
// - Busy bit shows transmit or receive activity
// - Exception disable picks form error or integrate
// - Standard CRC bit selects stuff count, seed
// - Filter count above eighteen is invalid
`include "can_control_consts.svh"

module can_control #(
   parameter int GAP_CODE_BITS = 4
) (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // Register port
   input  wire can_control_pkg::reg_req_t regReq,
   output logic [31:0]                   regRdata,
   // Protocol engine status
   input  wire logic                     txActive,
   input  wire logic                     rxActive,
   input  wire logic                     modeReady,
   input  wire logic                     systemError,
   input  wire logic                     allAborted,
   input  wire logic                     msgEsi,
   input  wire logic                     errorPassive,
   input  wire logic                     msgBrs,
   input  wire logic                     bitTick,
   input  wire logic                     txDone,
   // Controls to the protocol engine
   output can_control_pkg::ctrl_t        ctrl,
   output can_control_pkg::mode_t        activeMode,
   output logic                          abortRequest,
   output logic                          txEsiRecessive,
   output logic                          txRateSwitch,
   output logic                          txGapHold,
   output logic                          filterCountInvalid
);
   import can_control_pkg::*;

   if (GAP_CODE_BITS != 4) begin : g_bad_gap_bits
      $error("gap code must be 4 bits");
   end

   //--------------------------------------------------------------
   // Register state
   //--------------------------------------------------------------
   logic [3:0]  gapSelect, next_gapSelect;
   logic        abortBit, next_abortBit;
   mode_t       modeRequest, next_modeRequest;
   mode_t       next_activeMode;
   ctrl_t       next_ctrl;
   logic [1:0]  wakeFilterTime, next_wakeFilterTime;
   logic        wakeFilter, next_wakeFilter;
   logic        busy;
   logic [31:0] wr;
   logic [31:0] rdWord;
   logic [3:0]  settle, next_settle;
   logic [12:0] gapCount, next_gapCount;
   logic [12:0] gapLength;
   logic        inConfig;

   assign inConfig = (activeMode == MODE_CONFIG);
   assign wr = regReq.wdata;

   always_comb begin
      next_gapSelect      = gapSelect;
      next_abortBit       = abortBit;
      next_modeRequest    = modeRequest;
      next_ctrl           = ctrl;
      next_wakeFilterTime = wakeFilterTime;
      next_wakeFilter     = wakeFilter;
      if (regReq.write && regReq.byteEn[3]) begin
         next_gapSelect   = wr[`CC_GAP_MSB:`CC_GAP_LSB];
         next_modeRequest = mode_t'(wr[`CC_REQ_MSB:`CC_REQ_LSB]);
         if (wr[`CC_ABORT_BIT]) begin
            next_abortBit = 1'b1;
         end
      end
      if (regReq.write && regReq.byteEn[1]) begin
         next_ctrl.rateSwitchDisable = wr[`CC_BRS_BIT];
         next_wakeFilterTime         = wr[`CC_WFT_MSB:`CC_WFT_LSB];
         if (inConfig) begin
            next_wakeFilter = wr[`CC_WAKE_BIT];
         end
      end
      if (regReq.write && regReq.byteEn[2]) begin
         next_ctrl.systemErrorModeSelect = wr[`CC_SERR_BIT];
         if (inConfig) begin
            next_ctrl.transmitQueueEnable = wr[`CC_TXQ_BIT];
            next_ctrl.eventStoreEnable    = wr[`CC_STORE_BIT];
            next_ctrl.gatewayEsiMode      = wr[`CC_ESI_BIT];
            next_ctrl.retransmitRestrict  = wr[`CC_RTX_BIT];
         end
      end
      if (regReq.write && regReq.byteEn[0] && inConfig) begin
         next_ctrl.protocolExceptionDisable = wr[`CC_PXE_BIT];
         next_ctrl.standardCrcEnable        = wr[`CC_CRC_BIT];
         next_ctrl.dataByteFilterCount      = wr[`CC_DN_MSB:`CC_DN_LSB];
      end
      // Hardware clear only once every FIFO reports done; a set in the same cycle wins
      if (abortBit && allAborted && !(regReq.write && regReq.byteEn[3] && wr[`CC_ABORT_BIT])) begin
         next_abortBit = 1'b0;
      end
      // System error overrides the request with the chosen fallback mode
      if (systemError) begin
         next_modeRequest = next_ctrl.systemErrorModeSelect ? MODE_LISTEN : MODE_RESTRICTED;
      end
      next_ctrl.fdAllowed = (activeMode != MODE_CLASSIC);
   end

   //--------------------------------------------------------------
   // Mode sequencing
   //--------------------------------------------------------------
   always_comb begin
      next_activeMode = activeMode;
      next_settle     = settle;
      if (modeRequest == activeMode) begin
         next_settle = `CC_MODE_SETTLE;
      end else if (settle != 4'h0) begin
         next_settle = settle - 4'h1;
      end else if (modeReady) begin
         next_activeMode = modeRequest;
         next_settle     = `CC_MODE_SETTLE;
      end
   end

   //--------------------------------------------------------------
   // Transmit gap
   //--------------------------------------------------------------
   always_comb begin
      if (gapSelect == 4'h0) begin
         gapLength = 13'h0;
      end else if (gapSelect >= `CC_GAP_SAT) begin
         gapLength = 13'h1000;
      end else begin
         gapLength = 13'h1 << gapSelect;
      end
   end

   always_comb begin
      next_gapCount = gapCount;
      if (txDone) begin
         next_gapCount = gapLength;
      end else if (bitTick && gapCount != 13'h0) begin
         next_gapCount = gapCount - 13'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gapSelect      <= 4'h0;
         abortBit       <= 1'b0;
         modeRequest    <= MODE_CONFIG;
         activeMode     <= MODE_CONFIG;
         ctrl           <= '{transmitQueueEnable: 1'b1, eventStoreEnable: 1'b1,
                             protocolExceptionDisable: 1'b1, standardCrcEnable: 1'b1,
                             fdAllowed: 1'b1, default: '0};
         wakeFilterTime <= 2'h3;
         wakeFilter     <= 1'b1;
         settle         <= `CC_MODE_SETTLE;
         gapCount       <= 13'h0;
      end else begin
         gapSelect      <= next_gapSelect;
         abortBit       <= next_abortBit;
         modeRequest    <= next_modeRequest;
         activeMode     <= next_activeMode;
         ctrl           <= next_ctrl;
         wakeFilterTime <= next_wakeFilterTime;
         wakeFilter     <= next_wakeFilter;
         settle         <= next_settle;
         gapCount       <= next_gapCount;
      end
   end

   //--------------------------------------------------------------
   // Derived outputs
   //--------------------------------------------------------------
   assign busy               = txActive | rxActive;
   assign abortRequest       = abortBit;
   assign txGapHold          = (gapCount != 13'h0);
   assign txEsiRecessive     = ctrl.gatewayEsiMode ? (msgEsi | errorPassive) : errorPassive;
   assign txRateSwitch       = msgBrs & ~ctrl.rateSwitchDisable;
   assign filterCountInvalid = (ctrl.dataByteFilterCount > `CC_DN_MAX);

   //--------------------------------------------------------------
   // Read data
   //--------------------------------------------------------------
   always_comb begin
      rdWord = 32'h0;
      rdWord[`CC_GAP_MSB:`CC_GAP_LSB]   = gapSelect;
      rdWord[`CC_ABORT_BIT]             = abortBit;
      rdWord[`CC_REQ_MSB:`CC_REQ_LSB]   = modeRequest;
      rdWord[`CC_STAT_MSB:`CC_STAT_LSB] = activeMode;
      rdWord[`CC_TXQ_BIT]               = ctrl.transmitQueueEnable;
      rdWord[`CC_STORE_BIT]             = ctrl.eventStoreEnable;
      rdWord[`CC_SERR_BIT]              = ctrl.systemErrorModeSelect;
      rdWord[`CC_ESI_BIT]               = ctrl.gatewayEsiMode;
      rdWord[`CC_RTX_BIT]               = ctrl.retransmitRestrict;
      rdWord[`CC_BRS_BIT]               = ctrl.rateSwitchDisable;
      rdWord[`CC_BUSY_BIT]              = busy;
      rdWord[`CC_WFT_MSB:`CC_WFT_LSB]   = wakeFilterTime;
      rdWord[`CC_WAKE_BIT]              = wakeFilter;
      rdWord[`CC_PXE_BIT]               = ctrl.protocolExceptionDisable;
      rdWord[`CC_CRC_BIT]               = ctrl.standardCrcEnable;
      rdWord[`CC_DN_MSB:`CC_DN_LSB]     = ctrl.dataByteFilterCount;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regRdata <= `CC_RESET_VALUE;
      end else if (regReq.read) begin
         regRdata <= rdWord;
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   sequence s_cfgWrite;
      regReq.write && regReq.byteEn[2] && !inConfig;
   endsequence

   property p_cfg_lock;
      @(posedge sys_clk) disable iff (rst)
      s_cfgWrite |=> $stable(ctrl.transmitQueueEnable) && $stable(ctrl.gatewayEsiMode);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock) else $error("config-only field changed outside config");

   property p_abort_hold;
      @(posedge sys_clk) disable iff (rst)
      abortBit && !allAborted |=> abortBit;
   endproperty
   a_abort_hold: assert property (p_abort_hold) else $error("abort cleared early");

   property p_abort_clear;
      @(posedge sys_clk) disable iff (rst)
      abortBit && allAborted && !regReq.write |=> !abortBit;
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("abort not cleared");

   property p_mode_settle;
      @(posedge sys_clk) disable iff (rst)
      $changed(activeMode) |-> $past(modeReady) && activeMode == $past(modeRequest);
   endproperty
   a_mode_settle: assert property (p_mode_settle) else $error("mode changed without ready");

   property p_serr;
      @(posedge sys_clk) disable iff (rst)
      systemError |=> modeRequest == ($past(next_ctrl.systemErrorModeSelect) ? MODE_LISTEN : MODE_RESTRICTED);
   endproperty
   a_serr: assert property (p_serr) else $error("wrong system error mode");

   property p_gap;
      @(posedge sys_clk) disable iff (rst)
      txDone && gapSelect == 4'hf |=> gapCount == 13'h1000;
   endproperty
   a_gap: assert property (p_gap) else $error("gap not saturated");

   property p_esi;
      @(posedge sys_clk) disable iff (rst)
      !ctrl.gatewayEsiMode |-> txEsiRecessive == errorPassive;
   endproperty
   a_esi: assert property (p_esi) else $error("esi does not follow error state");

   property p_abort_set;
      @(posedge sys_clk) disable iff (rst)
      regReq.write && regReq.byteEn[3] && regReq.wdata[`CC_ABORT_BIT] |=> abortBit;
   endproperty
   a_abort_set: assert property (p_abort_set) else $error("abort not set");

   property p_fd_mode;
      @(posedge sys_clk) disable iff (rst)
      activeMode == MODE_CLASSIC |=> !ctrl.fdAllowed;
   endproperty
   a_fd_mode: assert property (p_fd_mode) else $error("fd allowed in classic mode");

   property p_brs;
      @(posedge sys_clk) disable iff (rst)
      ctrl.rateSwitchDisable |-> !txRateSwitch;
   endproperty
   a_brs: assert property (p_brs) else $error("rate switch while disabled");

   property p_read_zero;
      @(posedge sys_clk) disable iff (rst)
      regReq.read |=> regRdata[15:13] == 3'h0 && regRdata[7] == 1'b0;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("unimplemented bits nonzero");

   property p_busy;
      @(posedge sys_clk) disable iff (rst)
      regReq.read && (txActive || rxActive) |=> regRdata[`CC_BUSY_BIT];
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
endmodule : can_control

// >>> bench/engine_model.sv
// Behavioural protocol engine facing the CAN control register
module engine_model #(
   parameter int TICK_DIV    = 2,
   parameter int ABORT_DELAY = 20
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Commands
   input  wire logic frameGo,
   input  wire logic abortRequest,
   // Engine status
   output logic      txActive,
   output logic      rxActive,
   output logic      modeReady,
   output logic      allAborted,
   output logic      bitTick
);
   timeunit 1ns;
   timeprecision 1ps;
   int tickCnt;
   int frameCnt;
   int abortCnt;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tickCnt <= 0;
         frameCnt <= 0;
         abortCnt <= 0;
      end else begin
         tickCnt <= (tickCnt == TICK_DIV - 1) ? 0 : tickCnt + 1;
         frameCnt <= frameGo ? 16 : (frameCnt > 0 ? frameCnt - 1 : 0);
         abortCnt <= abortRequest ? abortCnt + 1 : 0;
      end
   end
   assign bitTick    = (tickCnt == TICK_DIV - 1);
   assign txActive   = (frameCnt > 6);
   assign rxActive   = (frameCnt > 0) && (frameCnt <= 6);
   // Mode switches wait until the bus is quiet
   assign modeReady  = (frameCnt == 0);
   // Abort acknowledged only after a slow drain of the FIFOs
   assign allAborted = (abortCnt >= ABORT_DELAY);
endmodule : engine_model

// >>> bench/can_control_tb_top.sv
// Self-checking testbench of the CAN control register
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module can_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import can_control_pkg::*;
   logic sys_clk, rst, frameGo, systemError, msgEsi, errorPassive, msgBrs, txDone;
   logic txActive, rxActive, modeReady, allAborted, bitTick, abortRequest;
   logic txEsiRecessive, txRateSwitch, txGapHold, filterCountInvalid;
   reg_req_t regReq;
   logic [31:0] regRdata, r;
   ctrl_t ctrl;
   mode_t activeMode;
   logic [2:0] curMode;
   int failures, checks_done, cycles, n, e, k;
   logic [3:0] gaps [6] = '{4'h0, 4'h1, 4'h5, 4'hb, 4'hc, 4'hf};
   // ----------------------------------------
   // Design and engine
   // ----------------------------------------
   can_control can_control_inst (.sys_clk(sys_clk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
      .txActive(txActive), .rxActive(rxActive), .modeReady(modeReady), .systemError(systemError),
      .allAborted(allAborted), .msgEsi(msgEsi), .errorPassive(errorPassive), .msgBrs(msgBrs),
      .bitTick(bitTick), .txDone(txDone), .ctrl(ctrl), .activeMode(activeMode),
      .abortRequest(abortRequest), .txEsiRecessive(txEsiRecessive), .txRateSwitch(txRateSwitch),
      .txGapHold(txGapHold), .filterCountInvalid(filterCountInvalid));
   engine_model engine_model_inst (.sys_clk(sys_clk), .rst(rst), .frameGo(frameGo),
      .abortRequest(abortRequest), .txActive(txActive), .rxActive(rxActive), .modeReady(modeReady),
      .allAborted(allAborted), .bitTick(bitTick));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [31:0] d, input logic [3:0] be);
      @(posedge sys_clk); #1;
      regReq.write = 1'b1;
      regReq.wdata = d;
      regReq.byteEn = be;
      @(posedge sys_clk); #1;
      regReq.write = 1'b0;
   endtask : wr
   task automatic rd(output logic [31:0] d);
      @(posedge sys_clk); #1;
      regReq.read = 1'b1;
      @(posedge sys_clk); #1;
      regReq.read = 1'b0;
      @(posedge sys_clk); #1;
      d = regRdata;
   endtask : rd
   task automatic pulse(ref logic s);
      @(posedge sys_clk); #1;
      s = 1'b1;
      @(posedge sys_clk); #1;
      s = 1'b0;
   endtask : pulse
   task automatic wait_mode(input logic [2:0] m);
      for (int i = 0; i < 40 && activeMode !== m; i++) @(posedge sys_clk) #1;
      `CHK("mode status", m, activeMode)
      curMode = m;
   endtask : wait_mode
   task automatic set_mode(input logic [2:0] m);
      wr({5'h00, m, 24'h0}, 4'h8);
      `CHK("mode held", curMode, activeMode)
      wait_mode(m);
   endtask : set_mode
   // ----------------------------------------
   // Clock, timeout and tests
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 70000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      {rst, frameGo, systemError, msgEsi, errorPassive, msgBrs, txDone} = 7'h40;
      regReq = '0;
      curMode = MODE_CONFIG;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      rd(r);
      `CHK("reset value", 32'h0498_0760, r)
      wr(32'h0000_f07f, 4'h3);
      rd(r);
      `CHK("low half", 32'h0498_107f, r)
      `CHK("filter invalid", 1'b1, filterCountInvalid)
      wr(32'h0000_0072, 4'h1);
      `CHK("filter max ok", 1'b0, filterCountInvalid)
      `CHK("filter count", 5'h12, ctrl.dataByteFilterCount)
      wr(32'h0000_0000, 4'h1);
      `CHK("pxe crc off", 2'b00, {ctrl.protocolExceptionDisable, ctrl.standardCrcEnable})
      wr(32'h001f_0000, 4'h4);
      `CHK("lane2 fields", 5'h1f, ctrl[13:9])
      for (int i = 0; i < 16; i++) begin
         wr({8'h0, 5'h03, 1'b0, i[2], 1'b0, 3'b000, i[3], 12'h000}, 4'h6);
         {errorPassive, msgEsi, msgBrs} = {i[1], i[0], i[0]};
         #1;
         `CHK("esi", i[2] ? (i[0] | i[1]) : i[1], txEsiRecessive)
         `CHK("rate switch", i[0] & ~i[3], txRateSwitch)
      end
      for (int m = 0; m < 8; m++) begin
         if (m != 4) begin
            set_mode(m[2:0]);
            rd(r);
            `CHK("mode fields", {m[2:0], m[2:0]}, r[26:21])
            if (m == 0 || m == 6) `CHK("fd allowed", m == 0, ctrl.fdAllowed)
            wr(32'h0000_007f, 4'h5);
            `CHK("refused", 6'h20, {ctrl.transmitQueueEnable, ctrl.dataByteFilterCount})
            set_mode(MODE_CONFIG);
         end
      end
      wr(32'h001c_0000, 4'h4);
      for (int j = 0; j < 2; j++) begin
         set_mode(MODE_NORMAL_FD);
         pulse(systemError);
         wait_mode(j == 0 ? MODE_LISTEN : MODE_RESTRICTED);
         wr(32'h0018_0000, 4'h4);
      end
      set_mode(MODE_CONFIG);
      pulse(frameGo);
      rd(r);
      `CHK("busy", 1'b1, r[11])
      repeat (20) @(posedge sys_clk);
      rd(r);
      `CHK("idle", 1'b0, r[11])
      wr(32'h0c00_0000, 4'h8);
      `CHK("abort set", 1'b1, abortRequest)
      wr(32'h0400_0000, 4'h8);
      `CHK("abort kept", 1'b1, abortRequest)
      for (k = 0; k < 60 && abortRequest !== 1'b0; k++) @(posedge sys_clk) #1;
      `CHK("abort cleared", 1'b0, abortRequest)
      `CHK("abort waited", 1'b1, k >= 10)
      foreach (gaps[g]) begin
         wr({gaps[g], 4'h4, 24'h0}, 4'h8);
         e = (gaps[g] == 0) ? 0 : (gaps[g] >= 12) ? 4096 : (1 << gaps[g]);
         pulse(txDone);
         n = 0;
         for (k = 0; k < 9000 && txGapHold === 1'b1; k++) begin
            if (bitTick === 1'b1) n++;
            @(posedge sys_clk) #1;
         end
         `CHK("gap ticks", 1'b1, n + 1 >= e && n <= e + 1)
      end
      final_report();
   end
endmodule : can_control_tb_top
